/* File: hdl/escs_top.sv */
// Chip-select decode, configuration registers and access sequencer.
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module escs_top
  import escs_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // System access request
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic [31:0] acc_addr,
  input wire logic [15:0] acc_wdata,
  input wire logic [1:0] acc_be,
  output logic [15:0] acc_rdata,
  output logic acc_done,
  output logic acc_busy,
  // External pins
  output logic [23:0] external_address_pins,
  output logic [3:0] chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [1:0] byte_lane_n,
  output logic [15:0] data_out,
  output logic data_oe,
  input wire logic [15:0] data_in,
  input wire logic [2:0] ready_in,
  output logic flash_reset_n,
  output logic flash_powerdown_n
);
  // Configuration registers
  logic [31:0] base_r [NCS];
  logic [31:0] win_r [NCS];
  logic [31:0] tim_r [NSET];
  logic [31:0] hold_r, smcon_r, addrcfg_r, ctlcfg_r;
  logic [31:0] next_base [NCS];
  logic [31:0] next_win [NCS];
  logic [31:0] next_tim [NSET];
  logic [31:0] next_hold, next_smcon, next_addrcfg, next_ctlcfg, next_rdata;
  // Sequencer state
  escs_state_e state, next_state;
  logic [11:0] cnt, next_cnt;
  logic [3:0] cs_n, next_cs_n;
  logic rd_n, next_rd_n, wr_n, next_wr_n, oe, next_oe, done, next_done;
  logic [23:0] apin, next_apin;
  logic [1:0] lane_n, next_lane_n;
  logic [15:0] dout, next_dout, rdat, next_rdat;
  logic frst_n, next_frst_n, fpd_n, next_fpd_n;
  logic [3:0] hits;
  logic [3:0] hit_lat, next_hit_lat;
  logic [1:0] set_sel;
  logic byte_wide, wr_q, next_wr_q, rdy_ok;
  logic [2:0] wid;
  logic [31:0] tim;

  genvar g;
  generate
    for (g = 0; g < NCS; g++) begin : g_dec
      escs_decode u_dec (
        .base(base_r[g][31:16]),
        .size_code(win_r[g][SIZE_LSB +: 5]),
        .addr(acc_addr),
        .hit(hits[g])
      );
    end
  endgenerate

  // Register writes and reads
  always_comb begin
    next_base = base_r;
    next_win = win_r;
    next_tim = tim_r;
    next_hold = hold_r;
    next_smcon = smcon_r;
    next_addrcfg = addrcfg_r;
    next_ctlcfg = ctlcfg_r;
    next_rdata = 32'h00000000;
    for (int i = 0; i < NCS; i++) begin
      if (reg_write && reg_addr == OFS_BASE0 + 8'(i) * OFS_STRIDE) begin
        next_base[i] = reg_wdata & BASE_MASK;
      end
      if (reg_write && reg_addr == OFS_WIN0 + 8'(i) * OFS_STRIDE) begin
        next_win[i] = reg_wdata & WIN_MASK;
      end
      if (reg_read && reg_addr == OFS_BASE0 + 8'(i) * OFS_STRIDE) begin
        next_rdata = base_r[i];
      end
      if (reg_read && reg_addr == OFS_WIN0 + 8'(i) * OFS_STRIDE) begin
        next_rdata = win_r[i];
      end
    end
    for (int j = 0; j < NSET; j++) begin
      if (reg_write && reg_addr == OFS_TIM0 + 8'(j) * 8'h04) begin
        next_tim[j] = reg_wdata & TIM_MASK;
      end
      if (reg_read && reg_addr == OFS_TIM0 + 8'(j) * 8'h04) begin
        next_rdata = tim_r[j];
      end
    end
    // Single registers
    if (reg_write) begin
      case (reg_addr)
        OFS_HOLD: next_hold = reg_wdata & HOLD_MASK;
        OFS_SMCON: next_smcon = reg_wdata & SMCON_MASK;
        OFS_ADDRCFG: next_addrcfg = reg_wdata & ADDRCFG_MASK;
        OFS_CTLCFG: next_ctlcfg = reg_wdata & CTLCFG_MASK;
        default: next_hold = hold_r;
      endcase
    end
    if (reg_read) begin
      case (reg_addr)
        OFS_HOLD: next_rdata = hold_r;
        OFS_SMCON: next_rdata = smcon_r;
        OFS_ADDRCFG: next_rdata = addrcfg_r;
        OFS_CTLCFG: next_rdata = ctlcfg_r;
        OFS_STATUS: next_rdata = {24'h000000, state, hit_lat};
        default: next_rdata = next_rdata;
      endcase
    end
  end

  // Register flops
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < NCS; i++) begin
        base_r[i] <= 32'h00000000;
        win_r[i] <= WIN_RST;
      end
      for (int j = 0; j < NSET; j++) begin
        tim_r[j] <= TIM_RST;
      end
      hold_r <= HOLD_RST;
      smcon_r <= SMCON_RST;
      addrcfg_r <= 32'h00000000;
      ctlcfg_r <= 32'h00000000;
      reg_rdata <= 32'h00000000;
    end else begin
      base_r <= next_base;
      win_r <= next_win;
      tim_r <= next_tim;
      hold_r <= next_hold;
      smcon_r <= next_smcon;
      addrcfg_r <= next_addrcfg;
      ctlcfg_r <= next_ctlcfg;
      reg_rdata <= next_rdata;
    end
  end

  // Timing set, width and ready of the latched channel
  always_comb begin
    set_sel = 2'b00;
    for (int i = 0; i < NCS; i++) begin
      // selector codes, reserved maps to set 0
      if (hit_lat[i] && win_r[i][SEL_LSB +: 3] <= SEL_MAX) begin
        set_sel = win_r[i][SEL_LSB +: 2];
      end
    end
    tim = tim_r[set_sel];
    wid = smcon_r[WID0_LSB + 3 * set_sel +: 3];
    // width codes, reserved treated as 16
    byte_wide = (wid == WID_8);
    rdy_ok = !tim[26] || !ctlcfg_r[16 + set_sel] || (ready_in[set_sel] ^ ctlcfg_r[24 + set_sel]);
  end

  // Access sequencer next state
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_cs_n = cs_n;
    next_rd_n = rd_n;
    next_wr_n = wr_n;
    next_oe = oe;
    next_apin = apin;
    next_lane_n = lane_n;
    next_dout = dout;
    next_rdat = rdat;
    next_done = 1'b0;
    next_frst_n = frst_n;
    next_fpd_n = fpd_n;
    next_hit_lat = hit_lat;
    next_wr_q = wr_q;
    case (state)
      ST_HOLD: begin
        if (cnt >= hold_r[11:0]) begin
          next_frst_n = 1'b1;
          next_fpd_n = 1'b1;
          next_state = ST_IDLE;
        end else begin
          next_cnt = cnt + 12'd1;
        end
      end
      ST_IDLE: begin
        if (acc_req && hits != 4'h0) begin
          next_hit_lat = hits;
          next_cs_n = ~hits;
          next_wr_q = acc_write;
          // top four pins each by its own enable, all pins zero unless PINEN_BIT is set
          next_apin = acc_addr[23:0] & {addrcfg_r[23:20], 20'hFFFFF};
          if (!addrcfg_r[PINEN_BIT]) begin
            next_apin = 24'h000000;
          end
          next_lane_n = ~acc_be;
          next_dout = acc_wdata;
          next_oe = acc_write;
          next_rd_n = acc_write;
          next_wr_n = !acc_write;
          next_cnt = 12'd0;
          next_state = ST_ACT;
        end
      end
      ST_ACT: begin
        next_cnt = cnt + 12'd1;
        if ((wr_q ? cnt >= {6'h00, tim[15:10]} : cnt >= {6'h00, tim[5:0]}) && rdy_ok) begin
          next_rdat = byte_wide ? {8'h00, data_in[7:0]} : data_in;
          next_rd_n = 1'b1;
          next_wr_n = 1'b1;
          next_cnt = 12'd0;
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        // Address hold then release bus
        if (cnt >= {10'h000, tim[9:8]}) begin
          next_cs_n = 4'hF;
          next_oe = 1'b0;
          next_done = 1'b1;
          next_hit_lat = 4'h0;
          next_state = ST_IDLE;
        end else begin
          next_cnt = cnt + 12'd1;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Sequencer flops
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= ST_HOLD;
      cnt <= 12'd0;
      cs_n <= 4'hF;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      oe <= 1'b0;
      apin <= 24'h000000;
      lane_n <= 2'b11;
      dout <= 16'h0000;
      rdat <= 16'h0000;
      done <= 1'b0;
      hit_lat <= 4'h0;
      wr_q <= 1'b0;
      frst_n <= !SMCON_RST[FLASH_RESET_OR_POWERDOWN_SELECT_BIT];
      fpd_n <= SMCON_RST[FLASH_RESET_OR_POWERDOWN_SELECT_BIT];
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cs_n <= next_cs_n;
      rd_n <= next_rd_n;
      wr_n <= next_wr_n;
      oe <= next_oe;
      apin <= next_apin;
      lane_n <= next_lane_n;
      dout <= next_dout;
      rdat <= next_rdat;
      done <= next_done;
      hit_lat <= next_hit_lat;
      wr_q <= next_wr_q;
      frst_n <= next_frst_n;
      fpd_n <= next_fpd_n;
    end
  end

  // Registered outputs
  always_comb begin
    external_address_pins = apin;
    chip_select_n = cs_n;
    read_strobe_n = rd_n;
    write_strobe_n = wr_n;
    byte_lane_n = lane_n;
    data_out = dout;
    data_oe = oe;
    acc_rdata = rdat;
    acc_done = done;
    acc_busy = (state != ST_IDLE);
    flash_reset_n = frst_n;
    flash_powerdown_n = fpd_n;
  end
endmodule

/* File: hdl/escs_pkg.sv */
// Constants shared by the external static-memory chip-select block.
package escs_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_BASE0 = 8'h00;
  localparam logic [7:0] OFS_WIN0 = 8'h40;
  localparam logic [7:0] OFS_TIM0 = 8'h80;
  localparam logic [7:0] OFS_HOLD = 8'hA0;
  localparam logic [7:0] OFS_SMCON = 8'hA4;
  localparam logic [7:0] OFS_ADDRCFG = 8'hC0;
  localparam logic [7:0] OFS_CTLCFG = 8'hC4;
  localparam logic [7:0] OFS_STATUS = 8'hC8;
  localparam logic [7:0] OFS_STRIDE = 8'h10;
  // Field layouts
  localparam int BASE_LSB = 16;
  localparam int SEL_LSB = 8;
  localparam int KIND_LSB = 5;
  localparam int SIZE_LSB = 0;
  localparam int FLASH_RESET_OR_POWERDOWN_SELECT_BIT = 0;
  localparam int WID0_LSB = 7;
  localparam int PINEN_BIT = 31;
  // Writable masks
  localparam logic [31:0] BASE_MASK = 32'hFFFF0000;
  localparam logic [31:0] WIN_MASK = 32'h000007FF;
  localparam logic [31:0] TIM_MASK = 32'h07FFFFFF;
  localparam logic [31:0] HOLD_MASK = 32'h00000FFF;
  localparam logic [31:0] SMCON_MASK = 32'h0000FF81;
  localparam logic [31:0] ADDRCFG_MASK = 32'h80FFFFFF;
  localparam logic [31:0] CTLCFG_MASK = 32'h3F00FFFF;
  // Reset values
  localparam logic [31:0] WIN_RST = 32'h00000020;
  localparam logic [31:0] TIM_RST = 32'h04252044;
  localparam logic [31:0] HOLD_RST = 32'h00000010;
  localparam logic [31:0] SMCON_RST = 32'h00000001;
  // Codes
  localparam logic [2:0] SEL_MAX = 3'b010;
  localparam logic [2:0] KIND_SRAM = 3'b001;
  localparam logic [2:0] KIND_FLASH = 3'b010;
  localparam logic [4:0] SIZE_OFF = 5'b00000;
  localparam logic [4:0] SIZE_MAX = 5'b01001;
  localparam logic [2:0] WID_16 = 3'b000;
  localparam logic [2:0] WID_8 = 3'b100;
  localparam int NCS = 4;
  localparam int NSET = 3;
  // Access sequencer states
  typedef enum logic [3:0] {
    ST_HOLD = 4'b0001,
    ST_IDLE = 4'b0010,
    ST_ACT = 4'b0100,
    ST_DONE = 4'b1000
  } escs_state_e;
endpackage

/* File: hdl/escs_decode.sv */
// Window decoder for one chip-select channel.
`timescale 1ns/1ps
module escs_decode
  import escs_pkg::*;
(
  // Channel setup
  input wire logic [15:0] base,
  input wire logic [4:0] size_code,
  // Access address
  input wire logic [31:0] addr,
  // Hit result
  output logic hit
);
  // Window length in 64 KB blocks, zero when the channel is off
  logic [15:0] span_blocks;
  // Distance of the access above the base, in 64 KB blocks
  logic [15:0] offset;
  // Window runs from base up to base plus its size
  always_comb begin
    span_blocks = 16'h0000;
    offset = addr[31:16] - base;
    if ((size_code <= SIZE_MAX) && (size_code != SIZE_OFF)) begin
      span_blocks = 16'h0001 << (size_code - 5'd1);
    end
    hit = (addr[31:16] >= base) && (offset < span_blocks);
  end
endmodule

/* File: sim/escs_props.sv */
// Port-level checks for the chip-select block.
`timescale 1ns/1ps
module escs_props
  import escs_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  // Access status and pins
  input wire logic acc_done,
  input wire logic acc_busy,
  input wire logic [3:0] chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic flash_reset_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  property p_base_low; $past(reg_read) && $past(reg_addr) < OFS_WIN0 |-> reg_rdata[15:0] == 16'h0; endproperty
  a_base_low: assert property (p_base_low) else $error("base low half not zero");
  property p_hold_low; $fell(reset) |-> !flash_reset_n [*8]; endproperty
  a_hold_low: assert property (p_hold_low) else $error("flash reset released early");
  property p_hold_end; $fell(reset) |-> ##[12:24] flash_reset_n; endproperty
  a_hold_end: assert property (p_hold_end) else $error("flash reset never released");
  property p_quiet; !flash_reset_n |-> chip_select_n == 4'hF && acc_busy; endproperty
  a_quiet: assert property (p_quiet) else $error("access during flash reset");
  property p_excl; read_strobe_n || write_strobe_n; endproperty
  a_excl: assert property (p_excl) else $error("both strobes low");
  property p_strobe_cs; !(read_strobe_n && write_strobe_n) |-> chip_select_n != 4'hF; endproperty
  a_strobe_cs: assert property (p_strobe_cs) else $error("strobe without select");
  property p_onehot; $onehot0(~chip_select_n); endproperty
  a_onehot: assert property (p_onehot) else $error("two selects at once");
  property p_done; acc_done |=> !acc_done; endproperty
  a_done: assert property (p_done) else $error("done longer than one cycle");
endmodule

bind escs_top escs_props u_props (.*);

/* File: sim/escs_sram_model.sv */
// Behavioural asynchronous static memory on the external pins.
`timescale 1ns/1ps
module escs_sram_model (
  // Pins from the block
  input wire logic [23:0] external_address_pins,
  input wire logic [3:0] chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [1:0] byte_lane_n,
  input wire logic [15:0] data_out,
  // Data back to the block
  output logic [15:0] data_in
);
  // Word storage on the low address pins
  logic [15:0] mem [0:255];
  // lane store on rising write strobe
  always @(posedge write_strobe_n) begin
    if (chip_select_n != 4'hF && !byte_lane_n[0]) mem[external_address_pins[7:0]][7:0] = data_out[7:0];
    if (chip_select_n != 4'hF && !byte_lane_n[1]) mem[external_address_pins[7:0]][15:8] = data_out[15:8];
  end
  // drive while selected and reading, else a moving pattern
  initial data_in = 16'hA55A;
  always @(read_strobe_n, chip_select_n, external_address_pins) begin
    if (chip_select_n != 4'hF && !read_strobe_n) data_in = mem[external_address_pins[7:0]];
    else data_in = ~data_in;
  end
endmodule

/* File: sim/testbench.sv */
// Self-checking bench for the chip-select block.
`timescale 1ns/1ps
module testbench;
  import escs_pkg::*;
  // Stimulus and observed ports
  logic clock = 0, reset = 1, reg_write = 0, reg_read = 0, acc_req = 0, acc_write = 0, rd_d = 0, acc_rd = 0;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, acc_addr = 0, v;
  logic [15:0] acc_wdata = 0, acc_rdata, data_out, data_in, w;
  logic [1:0] acc_be = 0, byte_lane_n;
  logic [2:0] ready_in = 3'h7;
  logic acc_done, acc_busy, read_strobe_n, write_strobe_n, data_oe, flash_reset_n, flash_powerdown_n;
  logic [23:0] external_address_pins;
  logic [3:0] chip_select_n;
  // Expected answers, oldest first
  logic [31:0] rq[$];
  logic [15:0] aq[$];
  int fail_count = 0, cmp_count = 0;
  escs_top dut (.*);
  escs_sram_model mem (.*);
  initial forever #12.5 clock = ~clock;
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Writable bits of each offset, zero where unmapped
  function automatic logic [31:0] mask_of(input logic [7:0] a);
    if (a[3:0] == 4'h0 && a < OFS_TIM0) return a < OFS_WIN0 ? BASE_MASK : WIN_MASK;
    if (a >= OFS_TIM0 && a < OFS_TIM0 + 8'h0C) return TIM_MASK;
    case (a)
      OFS_HOLD: return HOLD_MASK;
      OFS_SMCON: return SMCON_MASK;
      OFS_ADDRCFG: return ADDRCFG_MASK;
      OFS_CTLCFG: return CTLCFG_MASK;
      default: return 32'h0;
    endcase
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
  endtask
  // Bounded wait for busy (0) or done (1)
  task automatic await(input int sel);
    for (int n = 0; n < 200; n++) begin
      @(negedge clock);
      if (sel ? acc_done : acc_busy) return;
    end
    fail_count++;
    end_of_test();
  endtask
  // One access; cs gives the expected selects, all high for a miss
  task automatic acc(input logic we, input logic [31:0] a, input logic [15:0] d, input logic [1:0] be,
                     input logic [3:0] cs, input logic [15:0] e);
    if (!we && cs != 4'hF) aq.push_back(e);
    @(posedge clock);
    acc_rd = !we && cs != 4'hF;
    acc_write <= we;
    acc_addr <= a;
    acc_wdata <= d;
    acc_be <= be;
    acc_req <= 1'b1;
    if (cs == 4'hF) begin
      repeat (6) @(negedge clock);
      check({31'h0, acc_busy}, 32'h0);
    end else begin
      await(0);
      check({8'h0, external_address_pins}, {8'h0, a[23:0]});
    end
    check({28'h0, chip_select_n}, {28'h0, cs});
    @(posedge clock);
    acc_req <= 1'b0;
    if (cs != 4'hF) await(1);
  endtask
  // Monitor pops the oldest note when an answer appears
  always @(posedge clock) rd_d <= reg_read;
  always @(negedge clock) begin
    if (rd_d) check(reg_rdata, rq.pop_front());
    if (acc_done && acc_rd) check({16'h0, acc_rdata}, {16'h0, aq.pop_front()});
  end
  initial begin
    void'($urandom(61));
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    check({31'h0, flash_reset_n}, 32'h0);
    for (int i = 0; i < NCS; i++) begin
      rd(8'(i) * OFS_STRIDE, 32'h0);
      rd(OFS_WIN0 + 8'(i) * OFS_STRIDE, WIN_RST);
    end
    for (int j = 0; j < NSET; j++) rd(OFS_TIM0 + 8'(4 * j), TIM_RST);
    rd(OFS_HOLD, HOLD_RST);
    rd(OFS_SMCON, SMCON_RST);
    repeat (8) @(negedge clock);
    check({30'h0, flash_reset_n, flash_powerdown_n}, 32'h3);
    // Random data through every offset up to OFS_CTLCFG, unmapped ones too
    for (int a = 0; a <= OFS_CTLCFG; a += 4) begin
      v = $urandom;
      wr(8'(a), v);
      rd(8'(a), v & mask_of(8'(a)));
    end
    // Four disjoint 64 KB windows, channel i on set i mod 3
    for (int i = 0; i < NCS; i++) begin
      wr(8'(i) * OFS_STRIDE, 32'h00010000 * (2 * i + 1));
      wr(OFS_WIN0 + 8'(i) * OFS_STRIDE, 32'((i % 3) << SEL_LSB) | 32'(KIND_SRAM) << KIND_LSB | 32'h1);
    end
    for (int j = 0; j < NSET; j++) wr(OFS_TIM0 + 8'(4 * j), 32'h00252144);
    wr(OFS_SMCON, SMCON_RST);
    wr(OFS_ADDRCFG, ADDRCFG_MASK);
    wr(OFS_CTLCFG, 32'h0);
    for (int i = 0; i < NCS; i++) begin
      v = 32'h00010000 * (2 * i + 1) + 32'(8 * i + 8);
      w = 16'($urandom);
      acc(1'b1, v, w, 2'b11, ~(4'h1 << i), 16'h0);
      acc(1'b0, v, 16'h0, 2'b11, ~(4'h1 << i), w);
    end
    // Low byte only on the wide bus
    acc(1'b1, 32'h00010040, 16'h1234, 2'b11, 4'hE, 16'h0);
    acc(1'b1, 32'h00010040, 16'hABCD, 2'b01, 4'hE, 16'h0);
    acc(1'b0, 32'h00010040, 16'h0, 2'b11, 4'hE, 16'h12CD);
    // Window edges and a disabled channel
    acc(1'b0, 32'h00020000, 16'h0, 2'b11, 4'hF, 16'h0);
    wr(OFS_WIN0, 32'(KIND_SRAM) << KIND_LSB | 32'h2);
    acc(1'b1, 32'h0002FFF0, 16'h5AA5, 2'b11, 4'hE, 16'h0);
    wr(OFS_WIN0 + 8'h30, 32'(KIND_SRAM) << KIND_LSB);
    acc(1'b0, 32'h00070008, 16'h0, 2'b11, 4'hF, 16'h0);
    // Second reset restores the registers
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rd(OFS_WIN0 + 8'h30, WIN_RST);
    rd(8'h10, 32'h0);
    repeat (30) @(posedge clock);
    end_of_test();
  end
endmodule
